//--- core/sensor_regs.sv
// configuration, hysteresis and alert limit registers with read mux
// assumes a synchronised active-low reset and writes from the port fsm
`timescale 1ns/1ps
`default_nettype none
`include "temp_sensor_defs.svh"
module sensor_regs (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // register access
    reg_access_if.regs rb
);
    logic [7:0] cfg_r;
    logic [15:0] hyst_r;
    logic [15:0] limit_r;
    logic [15:0] rd_data_r;
    wire [15:0] rd_sel;

    // config byte sits high so the first byte read is always right
    assign rd_sel = (rb.ptr == `PTR_TEMP) ? rb.temp_value :
                    (rb.ptr == `PTR_CFG) ? {cfg_r, 8'h00} :
                    (rb.ptr == `PTR_HYST) ? hyst_r :
                    (rb.ptr == `PTR_LIMIT) ? limit_r : 16'h0000;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_r <= `RST_CFG;
            hyst_r <= `RST_HYST;
            limit_r <= `RST_LIMIT;
        end else if (rb.wr_en) begin
            if (rb.ptr == `PTR_CFG)
                cfg_r <= rb.wr_data[7:0];
            if (rb.ptr == `PTR_HYST)
                hyst_r <= rb.wr_data;
            if (rb.ptr == `PTR_LIMIT)
                limit_r <= rb.wr_data;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)
            rd_data_r <= 16'h0000;
        else
            rd_data_r <= rd_sel;
    end

    assign rb.rd_data = rd_data_r;
    assign rb.cfg = cfg_r;
    assign rb.hyst = hyst_r;
    assign rb.limit = limit_r;
endmodule // sensor_regs
`default_nettype wire

//--- core/temp_sensor_i2c_slave_port.sv
// two-wire serial slave port and over-temperature alert of the sensor
// assumes scl/sda/select pins are asynchronous, temp_value is on ref_clk
`timescale 1ns/1ps
`default_nettype none
`include "temp_sensor_defs.svh"
module temp_sensor_i2c_slave_port
    import temp_sensor_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYCLES = `TIMEOUT_CYCLES_DEFAULT
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // serial bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // address select pins
    input wire logic addr_select_high,
    input wire logic addr_select_middle,
    input wire logic addr_select_low,
    // converter side
    input wire logic [15:0] temp_value,
    output logic oneshot_start,
    // alert pin level
    output logic overtemp_alert_output
);
    localparam int NPIN = 5;

    logic [1:0] rst_sync_r;
    logic [NPIN-1:0] meta_r;
    logic [NPIN-1:0] sync_r;
    logic scl_d_r;
    logic sda_d_r;
    port_state_type state_r, state_nxt;
    logic [3:0] bit_cnt_r, bit_cnt_nxt;
    logic [7:0] shift_r, shift_nxt;
    logic [1:0] byte_idx_r, byte_idx_nxt;
    logic rd_dir_r, rd_dir_nxt;
    logic oe_r, oe_nxt;
    logic [7:0] hi_byte_r, hi_byte_nxt;
    logic read_lo_r, read_lo_nxt;
    logic [2:0] ptr_r, ptr_nxt;
    logic wr_en_r, wr_en_nxt;
    logic [15:0] wr_data_r, wr_data_nxt;
    logic oneshot_r, oneshot_nxt;
    logic rd_clear_r, rd_clear_nxt;
    logic [31:0] tmo_cnt_r, tmo_cnt_nxt;
    logic cmp_active_r;
    logic int_active_r;
    logic armed_r;
    logic alert_r;
    logic sda_out_r;
    wire rst_s_n;
    wire [NPIN-1:0] pin_vec;
    wire scl, sda;
    wire [2:0] sel_pins;
    wire scl_rise, scl_fall, start_det, stop_det;
    wire lim_hit, below_hyst, alert_act, alert_nxt;
    wire [7:0] rd_byte;
    wire tmo_hit;

    reg_access_if rb ();

    function automatic logic addr_match(input logic [7:0] b,
                                        input logic [2:0] pins);
        addr_match = (b[7:1] == {`ADDR_FIXED, pins});
    endfunction

    // two's complement, sign in the top bit
    // compare the 12 significant bits as signed values
    function automatic logic temp_ge(input logic [15:0] a,
                                     input logic [15:0] b);
        temp_ge = ($signed(a[15:4]) >= $signed(b[15:4]));
    endfunction

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)
            rst_sync_r <= 2'h0;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
    assign rst_s_n = rst_sync_r[1];

    assign pin_vec = {scl_in, sda_in, addr_select_high,
                      addr_select_middle, addr_select_low};
    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_sync
            always_ff @(posedge ref_clk or negedge rst_s_n) begin
                if (!rst_s_n) begin
                    meta_r[gi] <= 1'b1;
                    sync_r[gi] <= 1'b1;
                end else begin
                    meta_r[gi] <= pin_vec[gi];
                    sync_r[gi] <= meta_r[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_d_r <= scl;
            sda_d_r <= sda;
        end
    end

    assign scl = sync_r[4];
    assign sda = sync_r[3];
    assign sel_pins = sync_r[2:0];
    assign scl_rise = scl & ~scl_d_r;
    assign scl_fall = ~scl & scl_d_r;
    assign start_det = scl & scl_d_r & ~sda & sda_d_r;
    assign stop_det = scl & scl_d_r & sda & ~sda_d_r;
    // upper byte first; config always in the upper lane
    assign rd_byte = read_lo_r ? rb.rd_data[7:0] : rb.rd_data[15:8];
    assign tmo_hit = (tmo_cnt_r >= TIMEOUT_CYCLES - 1);

    always_comb begin
        state_nxt = state_r;
        bit_cnt_nxt = bit_cnt_r;
        shift_nxt = shift_r;
        byte_idx_nxt = byte_idx_r;
        rd_dir_nxt = rd_dir_r;
        oe_nxt = oe_r;
        hi_byte_nxt = hi_byte_r;
        read_lo_nxt = read_lo_r;
        ptr_nxt = ptr_r;
        wr_en_nxt = 1'b0;
        wr_data_nxt = wr_data_r;
        oneshot_nxt = 1'b0;
        rd_clear_nxt = 1'b0;
        tmo_cnt_nxt = 32'h0;
        if (state_r != ST_IDLE && sda == sda_d_r)
            tmo_cnt_nxt = tmo_cnt_r + 32'h1;
        if (start_det) begin
            state_nxt = ST_ADDR;
            bit_cnt_nxt = 4'h0;
            byte_idx_nxt = 2'h0;
            oe_nxt = 1'b0;
        end else if (stop_det) begin
            state_nxt = ST_IDLE;
            oe_nxt = 1'b0;
        end else begin
            case (state_r)
                ST_ADDR, ST_WRITE: begin
                    if (scl_rise) begin
                        shift_nxt = {shift_r[6:0], sda};
                        bit_cnt_nxt = bit_cnt_r + 4'h1;
                    end else if (scl_fall
                                 && bit_cnt_r == `BITS_PER_BYTE) begin
                        bit_cnt_nxt = 4'h0;
                        if (state_r == ST_ADDR) begin
                            if (addr_match(shift_r, sel_pins)) begin
                                state_nxt = ST_ACK_ADDR;
                                oe_nxt = 1'b1;
                                rd_dir_nxt = shift_r[0];
                                rd_clear_nxt = shift_r[0];
                            end else begin
                                state_nxt = ST_IDLE;
                            end
                        end else begin
                            state_nxt = ST_ACK_WR;
                            oe_nxt = 1'b1;
                            if (byte_idx_r != `LAST_IDX)
                                byte_idx_nxt = byte_idx_r + 2'h1;
                            case (byte_idx_r)
                                2'h0: begin
                                    ptr_nxt = shift_r[2:0];
                                    oneshot_nxt = (shift_r[2:0]
                                                   == `PTR_ONESHOT);
                                end
                                2'h1: begin
                                    hi_byte_nxt = shift_r;
                                    if (ptr_r == `PTR_CFG) begin
                                        wr_en_nxt = 1'b1;
                                        wr_data_nxt = {8'h00, shift_r};
                                    end
                                end
                                2'h2: begin
                                    if (ptr_r == `PTR_HYST
                                        || ptr_r == `PTR_LIMIT) begin
                                        wr_en_nxt = 1'b1;
                                        wr_data_nxt = {hi_byte_r, shift_r};
                                    end
                                end
                                default: ;
                            endcase
                        end
                    end
                end
                ST_ACK_ADDR: begin
                    if (scl_fall) begin
                        if (rd_dir_r) begin
                            state_nxt = ST_READ;
                            shift_nxt = rb.rd_data[15:8];
                            oe_nxt = ~rb.rd_data[15];
                            read_lo_nxt = (ptr_r != `PTR_CFG);
                            bit_cnt_nxt = 4'h0;
                        end else begin
                            state_nxt = ST_WRITE;
                            oe_nxt = 1'b0;
                        end
                    end
                end
                ST_ACK_WR: begin
                    if (scl_fall) begin
                        state_nxt = ST_WRITE;
                        oe_nxt = 1'b0;
                    end
                end
                ST_READ: begin
                    // data moves only on falling clock
                    if (scl_fall) begin
                        if (bit_cnt_r == `LAST_BIT) begin
                            state_nxt = ST_RACK;
                            oe_nxt = 1'b0;
                            bit_cnt_nxt = 4'h0;
                        end else begin
                            shift_nxt = {shift_r[6:0], 1'b0};
                            oe_nxt = ~shift_r[6];
                            bit_cnt_nxt = bit_cnt_r + 4'h1;
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_rise && sda) begin
                        state_nxt = ST_WAIT;
                        oe_nxt = 1'b0;
                    end else if (scl_fall) begin
                        state_nxt = ST_READ;
                        shift_nxt = rd_byte;
                        oe_nxt = ~rd_byte[7];
                        read_lo_nxt = (ptr_r != `PTR_CFG) & ~read_lo_r;
                    end
                end
                default: ;
            endcase
        end
        if (tmo_hit && !start_det) begin
            state_nxt = ST_IDLE;
            oe_nxt = 1'b0;
            tmo_cnt_nxt = 32'h0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            state_r <= ST_IDLE;
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
            byte_idx_r <= 2'h0;
            rd_dir_r <= 1'b0;
            oe_r <= 1'b0;
            hi_byte_r <= 8'h00;
            read_lo_r <= 1'b0;
            ptr_r <= `RST_PTR;
            wr_en_r <= 1'b0;
            wr_data_r <= 16'h0000;
            oneshot_r <= 1'b0;
            rd_clear_r <= 1'b0;
            tmo_cnt_r <= 32'h0;
        end else begin
            state_r <= state_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            shift_r <= shift_nxt;
            byte_idx_r <= byte_idx_nxt;
            rd_dir_r <= rd_dir_nxt;
            oe_r <= oe_nxt;
            hi_byte_r <= hi_byte_nxt;
            read_lo_r <= read_lo_nxt;
            ptr_r <= ptr_nxt;
            wr_en_r <= wr_en_nxt;
            wr_data_r <= wr_data_nxt;
            oneshot_r <= oneshot_nxt;
            rd_clear_r <= rd_clear_nxt;
            tmo_cnt_r <= tmo_cnt_nxt;
        end
    end

    assign rb.wr_en = wr_en_r;
    assign rb.ptr = ptr_r;
    assign rb.wr_data = wr_data_r;
    assign rb.temp_value = temp_value;

    sensor_regs u_regs (
        .ref_clk(ref_clk),
        .rst_n(rst_s_n),
        .rb(rb.regs)
    );

    assign lim_hit = temp_ge(temp_value, rb.limit);
    assign below_hyst = ~temp_ge(temp_value, rb.hyst);
    assign alert_act = rb.cfg[`CFG_INT_BIT] ? int_active_r : cmp_active_r;
    assign alert_nxt = alert_act ^ ~rb.cfg[`CFG_POL_BIT];

    always_ff @(posedge ref_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            cmp_active_r <= 1'b0;
            int_active_r <= 1'b0;
            armed_r <= 1'b1;
            alert_r <= 1'b1;
            sda_out_r <= 1'b0;
        end else begin
            if (lim_hit)
                cmp_active_r <= 1'b1;
            else if (below_hyst)
                cmp_active_r <= 1'b0;
            if (lim_hit && armed_r)
                int_active_r <= 1'b1;
            else if (rd_clear_r)
                int_active_r <= 1'b0;
            // re-arm only after dropping under the limit
            armed_r <= lim_hit ? 1'b0 : 1'b1;
            alert_r <= alert_nxt;
            sda_out_r <= 1'b0;
        end
    end

    assign sda_out = sda_out_r;
    assign sda_oe = oe_r;
    assign oneshot_start = oneshot_r;
    assign overtemp_alert_output = alert_r;
endmodule // temp_sensor_i2c_slave_port
`default_nettype wire

//--- inc/reg_access_if.sv
// register access carrier between the port logic and the register file
// assumes both ends run on ref_clk
`timescale 1ns/1ps
`default_nettype none
interface reg_access_if;
    logic wr_en;
    logic [2:0] ptr;
    logic [15:0] wr_data;
    logic [15:0] temp_value;
    logic [15:0] rd_data;
    logic [7:0] cfg;
    logic [15:0] hyst;
    logic [15:0] limit;
    modport ctrl (output wr_en, ptr, wr_data, temp_value,
                  input rd_data, cfg, hyst, limit);
    modport regs (input wr_en, ptr, wr_data, temp_value,
                  output rd_data, cfg, hyst, limit);
endinterface
`default_nettype wire

//--- inc/temp_sensor_defs.svh
// constants of the temperature sensor serial slave port
// assumes inclusion by bare name from the package and the design files
`ifndef TEMP_SENSOR_DEFS_SVH
`define TEMP_SENSOR_DEFS_SVH
`define ADDR_FIXED 4'h9
`define PTR_TEMP 3'h0
`define PTR_CFG 3'h1
`define PTR_HYST 3'h2
`define PTR_LIMIT 3'h3
`define PTR_ONESHOT 3'h4
`define RST_CFG 8'h00
`define RST_HYST 16'h4B00
`define RST_LIMIT 16'h5000
`define RST_PTR 3'h0
`define CFG_INT_BIT 1
`define CFG_POL_BIT 2
`define BITS_PER_BYTE 4'h8
`define LAST_BIT 4'h7
`define LAST_IDX 2'h3
`define TIMEOUT_CYCLES_DEFAULT 1000000
`endif

//--- inc/temp_sensor_pkg.sv
// types shared by the serial slave port files
// assumes the defs header sits on the include path
`include "temp_sensor_defs.svh"
package temp_sensor_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_ACK_ADDR = 3'h2,
        ST_WRITE = 3'h3,
        ST_ACK_WR = 3'h4,
        ST_READ = 3'h5,
        ST_RACK = 3'h6,
        ST_WAIT = 3'h7
    } port_state_type;
endpackage

//--- tb/i2c_master_model.sv
// behavioural two-wire bus master, 200 ns bit time, 150 low 50 high
// assumes the bench resolves the open-drain data wire with a pull-up
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
    // bus pins
    output logic scl,
    output logic sda_lo,
    input wire logic sda
);
    // clock stands high between frames
    initial begin
        scl = 1'b1;
        sda_lo = 1'b0;
    end
    task automatic start();
        sda_lo = 1'b0;
        #150 scl = 1'b1;
        #100 sda_lo = 1'b1;
        #100 scl = 1'b0;
    endtask
    task automatic stop();
        sda_lo = 1'b1;
        #150 scl = 1'b1;
        #100 sda_lo = 1'b0;
        #100;
    endtask
    // eight bits plus slot, data moves only with clock low
    // a9 high releases the slot, a nack on the last read byte
    task automatic xfer(input logic [7:0] d, input logic a9,
                        output logic [7:0] q, output logic r9);
        logic [8:0] sh;
        sh = {d, a9};
        for (int i = 8; i >= 0; i--) begin
            #50 sda_lo = !sh[i];
            #100 scl = 1'b1;
            #25 sh[i] = sda;
            #25 scl = 1'b0;
        end
        q = sh[8:1];
        r9 = sh[0];
    endtask
endmodule // i2c_master_model
`default_nettype wire

//--- tb/temp_sensor_i2c_slave_port_tb.sv
// self-checking bench of the serial slave port
// assumes package, defs header, checker and master model compiled first
`timescale 1ns/1ps
`default_nettype none
`include "temp_sensor_defs.svh"
module temp_sensor_i2c_slave_port_tb;
    // short timeout keeps the stall scenario brief
    localparam int unsigned TMO = 200;
    logic ref_clk = 1'b0;
    logic rst_n, scl, sda_lo, sda, sda_out, sda_oe, oneshot_start, alert;
    logic [2:0] sel;
    logic [15:0] temp;
    int n_fail = 0;
    int comparisons = 0;
    int n_shot = 0;
    assign sda = !(sda_lo || (sda_oe && !sda_out));
    always #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (oneshot_start === 1'b1) n_shot++;
    temp_sensor_i2c_slave_port #(.TIMEOUT_CYCLES(TMO)) u_dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .addr_select_high(sel[2]),
        .addr_select_middle(sel[1]), .addr_select_low(sel[0]),
        .temp_value(temp), .oneshot_start(oneshot_start),
        .overtemp_alert_output(alert));
    i2c_master_model u_master (.scl(scl), .sda_lo(sda_lo), .sda(sda));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic set_temp(input logic [15:0] t);
        @(posedge ref_clk);
        #2 temp = t;
        repeat (3) @(posedge ref_clk);
        #2;
    endtask
    task automatic wr(input logic [2:0] ptr, input int n, input logic [15:0] d);
        logic [7:0] q;
        logic a;
        u_master.start();
        u_master.xfer({4'h9, sel, 1'b0}, 1'b1, q, a);
        check({15'h0, a}, 16'h0);
        u_master.xfer({5'h0, ptr}, 1'b1, q, a);
        if (n > 0) u_master.xfer(d[15:8], 1'b1, q, a);
        if (n > 1) u_master.xfer(d[7:0], 1'b1, q, a);
        check({15'h0, a}, 16'h0);
        u_master.stop();
    endtask
    task automatic rd(input int n, output logic [15:0] v);
        logic [7:0] q;
        logic a;
        v = 16'h0;
        u_master.start();
        u_master.xfer({4'h9, sel, 1'b1}, 1'b1, q, a);
        check({15'h0, a}, 16'h0);
        u_master.xfer(8'hFF, n == 1, q, a);
        v[15:8] = q;
        if (n > 1) u_master.xfer(8'hFF, 1'b1, q, a);
        if (n > 1) v[7:0] = q;
        check({15'h0, sda_oe}, 16'h0);
        u_master.stop();
    endtask
    task automatic t_defaults();
        logic [15:0] v;
        check({15'h0, alert}, 16'h1);
        set_temp(16'h1230);
        rd(2, v);
        check(v & 16'hFFF0, 16'h1230);
        wr(`PTR_LIMIT, 0, 16'h0);
        rd(2, v);
        check(v & 16'hFFF0, 16'h5000);
        rd(2, v);
        check(v & 16'hFFF0, 16'h5000);
    endtask
    task automatic t_address();
        logic [7:0] q;
        logic a;
        for (int i = 0; i < 8; i++) begin
            @(posedge ref_clk);
            #2 sel = i[2:0];
            repeat (4) @(posedge ref_clk);
            #2;
            u_master.start();
            u_master.xfer({4'h9, i[2:0] ^ 3'h1, 1'b0}, 1'b1, q, a);
            check({15'h0, a}, 16'h1);
            u_master.stop();
            // live select pins: the matching address is acked inside wr
            wr(`PTR_TEMP, 0, 16'h0);
        end
    endtask
    task automatic t_alert();
        logic [15:0] v;
        wr(`PTR_HYST, 2, 16'h1400);
        wr(`PTR_LIMIT, 2, 16'h1900);
        wr(`PTR_LIMIT, 1, 16'h7700);
        rd(2, v);
        check(v, 16'h1900);
        set_temp(16'hC900);
        check({15'h0, alert}, 16'h1);
        set_temp(16'h1900);
        check({15'h0, alert}, 16'h0);
        set_temp(16'h1700);
        check({15'h0, alert}, 16'h0);
        set_temp(16'h13F0);
        check({15'h0, alert}, 16'h1);
    endtask
    task automatic t_config();
        logic [15:0] v;
        wr(`PTR_CFG, 1, 16'h0400);
        check({15'h0, alert}, 16'h0);
        rd(1, v);
        check({8'h0, v[15:8]}, 16'h0004);
        wr(`PTR_CFG, 1, 16'h0000);
        check({15'h0, alert}, 16'h1);
        // interrupt behaviour: set on limit, cleared by a read
        wr(`PTR_CFG, 1, 16'h0200);
        check({15'h0, alert}, 16'h1);
        set_temp(16'h1900);
        check({15'h0, alert}, 16'h0);
        rd(1, v);
        check({8'h0, v[15:8]}, 16'h0002);
        check({15'h0, alert}, 16'h1);
        set_temp(16'h1300);
        wr(`PTR_CFG, 1, 16'h0000);
        check({15'h0, alert}, 16'h1);
    endtask
    task automatic t_oneshot();
        n_shot = 0;
        wr(`PTR_ONESHOT, 1, 16'hAB00);
        check(n_shot[15:0], 16'h1);
    endtask
    task automatic t_timeout();
        logic [7:0] q;
        logic a;
        logic [15:0] v;
        u_master.start();
        u_master.xfer({4'h9, sel, 1'b1}, 1'b1, q, a);
        #150 check({15'h0, sda_oe}, 16'h1);
        // master stalls the clock low while the device pulls data
        repeat (TMO + 40) @(posedge ref_clk);
        #2;
        check({15'h0, sda_oe}, 16'h0);
        u_master.stop();
        wr(`PTR_LIMIT, 0, 16'h0);
        rd(2, v);
        check(v, 16'h1900);
    endtask
    initial begin
        repeat (100000) @(posedge ref_clk);
        n_fail++;
        report_and_stop();
    end
    initial begin
        rst_n = 1'b0;
        sel = 3'h0;
        temp = 16'h0;
        repeat (16) @(posedge ref_clk);
        #2 rst_n = 1'b1;
        repeat (8) @(posedge ref_clk);
        t_defaults();
        t_address();
        t_alert();
        t_config();
        t_oneshot();
        t_timeout();
        report_and_stop();
    end
endmodule // temp_sensor_i2c_slave_port_tb
`default_nettype wire

//--- tb/temp_sensor_port_assertions.sv
// pin level checker of the serial slave port
// assumes binding to the port top module, ref_clk domain only
`timescale 1ns/1ps
`default_nettype none
module temp_sensor_port_checker #(
    parameter int unsigned TIMEOUT_CYCLES = 200
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // serial pins
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    // side outputs
    input wire logic oneshot_start,
    input wire logic overtemp_alert_output
);
    logic sda_q_r;
    logic [31:0] idle_cnt_r;
    // raw pin counter, runs a few cycles ahead of the synchronised copy
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sda_q_r <= 1'b1;
            idle_cnt_r <= 32'h0;
        end else begin
            sda_q_r <= sda_in;
            idle_cnt_r <= (sda_in != sda_q_r) ? 32'h0 : idle_cnt_r + 32'h1;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence start_seen;
        $fell(sda_in) && scl_in;
    endsequence
    sequence stop_seen;
        $rose(sda_in) && scl_in;
    endsequence
    a_drive_clock_low: assert property (
        $rose(sda_oe) |-> !scl_in) else $error("drive began, clock high");
    a_release_clock_low: assert property (
        $fell(sda_oe) |-> !scl_in || idle_cnt_r >= TIMEOUT_CYCLES - 4)
        else $error("drive ended, clock high");
    a_drive_min_width: assert property (
        $rose(sda_oe) |-> sda_oe [*6]) else $error("drive too short");
    a_start_no_drive: assert property (
        start_seen |-> !sda_oe [*8]) else $error("drive after start");
    a_stop_no_drive: assert property (
        stop_seen |=> !sda_oe [*8]) else $error("drive after stop");
    a_timeout_release: assert property (
        idle_cnt_r >= TIMEOUT_CYCLES + 8 |-> !sda_oe)
        else $error("data held past timeout");
    a_open_drain_low: assert property (
        sda_out == 1'b0) else $error("data output not low");
    a_alert_reset_idle: assert property (
        $rose(rst_n) |-> overtemp_alert_output) else $error("alert active");
    a_oneshot_single: assert property (
        oneshot_start |=> !oneshot_start) else $error("one-shot too long");
endmodule // temp_sensor_port_checker
bind temp_sensor_i2c_slave_port temp_sensor_port_checker #(
    .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
) u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .scl_in(scl_in),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .oneshot_start(oneshot_start),
    .overtemp_alert_output(overtemp_alert_output));
`default_nettype wire
